// ===== logic/smd_pkg.sv
package smd_pkg;
  // channel counts
  localparam int SMD_ADC_CH = 8;
  localparam int SMD_DAC_CH = 4;
  localparam int SMD_CODE_W = 8;
  localparam int SMD_ADC_W = 12;
  // margining code layout
  localparam logic [7:0] SMD_MIDCODE = 8'h7f;
  localparam logic [7:0] SMD_UPPER_RST = 8'hff;
  localparam logic [7:0] SMD_LOWER_RST = 8'h00;
  localparam logic [7:0] SMD_CODE_RST = 8'h7f;
  localparam logic [11:0] SMD_ADC_FULL = 12'hfff;
  // timing
  localparam int SMD_CLK_MHZ = 250;
  localparam int SMD_DWELL_US = 500;
  localparam int SMD_DWELL_CYCLES = SMD_DWELL_US * SMD_CLK_MHZ;
  localparam int SMD_DWELL_W = 17;
  localparam int SMD_TRACK_US = 2;
  localparam int SMD_TRACK_CYCLES = SMD_TRACK_US * SMD_CLK_MHZ;
  localparam int SMD_TRACK_W = 9;
  localparam int SMD_AVG_PASSES = 16;
  localparam int SMD_AVG_SHIFT = 4;
  // register byte offsets
  localparam logic [7:0] SMD_CTRL = 8'h00;
  localparam logic [7:0] SMD_CH_SEL = 8'h04;
  localparam logic [7:0] SMD_LIM_DIR = 8'h08;
  localparam logic [7:0] SMD_LIM_STAT = 8'h0c;
  localparam logic [7:0] SMD_INT_STAT = 8'h10;
  localparam logic [7:0] SMD_INT_MASK = 8'h14;
  localparam logic [7:0] SMD_THRESH = 8'h20;
  localparam logic [7:0] SMD_RESULT = 8'h40;
  localparam logic [7:0] SMD_MCODE = 8'h60;
  localparam logic [7:0] SMD_UCLAMP = 8'h70;
  localparam logic [7:0] SMD_LCLAMP = 8'h80;
  localparam logic [7:0] SMD_DCFG = 8'h90;
  // control bits
  localparam int SMD_CTRL_EN = 0;
  localparam int SMD_CTRL_CONT = 1;
  localparam int SMD_CTRL_AVG = 2;
  localparam int SMD_INT_PASS = 8;
  localparam int SMD_INT_W = 9;
  // dac range select, midcode 0.6/0.8/1.0/1.25 V
  typedef enum logic [1:0] {
    smd_mid_0v60, smd_mid_0v80, smd_mid_1v00, smd_mid_1v25
  } smd_range_t;
  // dac channel configuration
  typedef struct packed {
    smd_range_t range;
    logic enable;
  } smd_dac_cfg_t;
  localparam smd_dac_cfg_t SMD_DCFG_RST = '{range: smd_mid_0v60, enable: 1'b0};
  // dac channel drive to the analog side
  typedef struct packed {
    logic [7:0] code;
    smd_range_t range;
    logic hiz;
    logic track;
    logic drive;
  } smd_dac_out_t;
  // clamp pair from nonvolatile download
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } smd_clamp_t;
endpackage : smd_pkg

// ===== logic/smd_dac_chan.sv
`timescale 1ns/1ps
// one margining dac channel: clamp, three-state, glitchless enable
module smd_dac_chan
  import smd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] margin_code,
  input wire logic [7:0] margin_upper_clamp,
  input wire logic [7:0] margin_lower_clamp,
  input wire smd_dac_cfg_t cfg,
  output smd_dac_out_t dac_out
);
  logic inverted; // lower above upper
  logic [7:0] next_code; // clamped code
  logic [SMD_TRACK_W-1:0] track_cnt; // tracking time
  logic tracked; // tracking time over

  // clamp the written code into the window
  always_comb begin
    inverted = margin_lower_clamp > margin_upper_clamp;
    if (margin_code < margin_lower_clamp) begin
      next_code = margin_lower_clamp;
    end else if (margin_code > margin_upper_clamp) begin
      next_code = margin_upper_clamp;
    end else begin
      next_code = margin_code;
    end
  end

  // buffer follows the pin before it drives, avoids a glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_cnt <= '0;
      tracked <= 1'b0;
    end else if (!cfg.enable || inverted) begin
      track_cnt <= '0;
      tracked <= 1'b0;
    end else if (track_cnt == SMD_TRACK_W'(SMD_TRACK_CYCLES - 1)) begin
      tracked <= 1'b1;
    end else begin
      track_cnt <= track_cnt + 1'b1;
    end
  end

  // registered drive to the analog buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_out <= '{code: SMD_CODE_RST, range: smd_mid_0v60, hiz: 1'b1, track: 1'b0, drive: 1'b0};
    end else begin
      dac_out.code <= next_code;
      dac_out.range <= cfg.range;
      dac_out.hiz <= inverted || !tracked;
      dac_out.track <= cfg.enable && !inverted;
      dac_out.drive <= tracked && !inverted;
    end
  end
endmodule : smd_dac_chan

// ===== logic/smd_top.sv
`timescale 1ns/1ps
module smd_top
  import smd_pkg::*;
#(
  parameter int unsigned dwell_cycles = SMD_DWELL_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sequencing_engine_rr_on,
  output logic [SMD_ADC_CH-1:0] sequencing_engine_warn,
  output logic adc_start,
  output logic [2:0] adc_channel,
  input wire logic adc_done,
  input wire logic [SMD_ADC_W-1:0] adc_result,
  input wire logic nv_load,
  input wire smd_clamp_t [SMD_DAC_CH-1:0] nv_clamp,
  output smd_dac_out_t [SMD_DAC_CH-1:0] dac_out,
  output logic irq
);
  typedef enum logic [2:0] {
    st_idle, st_pick, st_conv, st_dwell, st_next, st_pass, st_hold
  } smd_rr_t;

  // software registers
  logic sw_en; // loop enable bit
  logic cont; // continuous loop
  logic avg; // averaging on
  logic [SMD_ADC_CH-1:0] ch_sel; // channels in the loop
  logic [SMD_ADC_CH-1:0] lim_dir; // 1 over, 0 under
  logic [SMD_ADC_W-1:0] thresh [SMD_ADC_CH]; // one limit each
  logic [SMD_ADC_W-1:0] result [SMD_ADC_CH]; // latest results
  logic [SMD_ADC_W+3:0] acc [SMD_ADC_CH]; // averaging sums
  logic [7:0] margin_code [SMD_DAC_CH];
  logic [7:0] margin_upper_clamp [SMD_DAC_CH];
  logic [7:0] margin_lower_clamp [SMD_DAC_CH];
  smd_dac_cfg_t dcfg [SMD_DAC_CH];
  logic [SMD_INT_W-1:0] int_stat; // sticky events
  logic [SMD_INT_W-1:0] int_mask; // 1 lets event through
  logic [SMD_ADC_CH-1:0] warn; // limit status

  // loop state
  smd_rr_t state;
  logic [2:0] ch; // channel under conversion
  logic [3:0] pass_cnt; // averaging pass count
  logic [SMD_DWELL_W-1:0] dwell_cnt; // per channel timer
  logic active; // loop requested
  logic once_done; // single pass finished
  logic publish; // warnings update now
  logic [SMD_ADC_CH-1:0] next_warn; // fresh comparisons
  logic [SMD_ADC_W-1:0] next_result [SMD_ADC_CH];

  // bus decode
  logic acc_ph; // access phase sample
  logic wr; // write takes effect
  logic [3:0] idx; // word inside a bank
  logic [3:0] bank; // upper address nibble
  logic [31:0] next_rdata;
  logic next_err;

  assign active = sw_en || sequencing_engine_rr_on;
  assign acc_ph = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign bank = paddr[7:4];
  assign idx = {2'b00, paddr[3:2]};

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= acc_ph;
      pslverr <= acc_ph && next_err;
      prdata <= (acc_ph && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // read mux and address check
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      next_err = 1'b1; // unaligned word
    end else begin
      unique case (bank)
        4'h0: begin
          unique case (paddr[3:2])
            2'b00: next_rdata = {29'h0, avg, cont, sw_en};
            2'b01: next_rdata = {24'h0, ch_sel};
            2'b10: next_rdata = {24'h0, lim_dir};
            2'b11: next_rdata = {24'h0, warn};
          endcase
        end
        4'h1: begin
          if (paddr[3:2] == 2'b00) begin
            next_rdata = {23'h0, int_stat};
          end else if (paddr[3:2] == 2'b01) begin
            next_rdata = {23'h0, int_mask};
          end else begin
            next_err = 1'b1;
          end
        end
        4'h2: next_rdata = {20'h0, thresh[paddr[4:2]]};
        4'h3: next_rdata = {20'h0, thresh[paddr[4:2]]};
        4'h4: next_rdata = {20'h0, result[paddr[4:2]]};
        4'h5: next_rdata = {20'h0, result[paddr[4:2]]};
        4'h6: next_rdata = {24'h0, margin_code[idx[1:0]]};
        4'h7: next_rdata = {24'h0, margin_upper_clamp[idx[1:0]]};
        4'h8: next_rdata = {24'h0, margin_lower_clamp[idx[1:0]]};
        4'h9: next_rdata = {29'h0, dcfg[idx[1:0]]};
        default: next_err = 1'b1; // unmapped
      endcase
    end
  end

  // loop control bits; a single pass clears the enable itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_en <= 1'b0;
      cont <= 1'b0;
      avg <= 1'b0;
      ch_sel <= '0;
      lim_dir <= '0;
    end else begin
      if (wr && paddr == SMD_CTRL) begin
        sw_en <= pwdata[SMD_CTRL_EN];
        cont <= pwdata[SMD_CTRL_CONT];
        avg <= pwdata[SMD_CTRL_AVG];
      end else if (once_done) begin
        sw_en <= 1'b0;
      end
      if (wr && paddr == SMD_CH_SEL) begin
        ch_sel <= pwdata[7:0];
      end
      if (wr && paddr == SMD_LIM_DIR) begin
        lim_dir <= pwdata[7:0];
      end
    end
  end

  // adc thresholds, full scale after reset so no over-limit channel trips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SMD_ADC_CH; i++) begin
        thresh[i] <= SMD_ADC_FULL;
      end
    end else if (wr && (bank == 4'h2 || bank == 4'h3)) begin
      thresh[paddr[4:2]] <= pwdata[SMD_ADC_W-1:0];
    end
  end

  // margin codes and configuration from the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SMD_DAC_CH; i++) begin
        margin_code[i] <= SMD_CODE_RST;
        dcfg[i] <= SMD_DCFG_RST;
      end
    end else if (wr && bank == 4'h6) begin
      margin_code[idx[1:0]] <= pwdata[7:0];
    end else if (wr && bank == 4'h9) begin
      dcfg[idx[1:0]] <= smd_dac_cfg_t'(pwdata[2:0]);
    end
  end

  // clamps: nonvolatile download wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SMD_DAC_CH; i++) begin
        margin_upper_clamp[i] <= SMD_UPPER_RST;
        margin_lower_clamp[i] <= SMD_LOWER_RST;
      end
    end else if (nv_load) begin
      for (int i = 0; i < SMD_DAC_CH; i++) begin
        margin_upper_clamp[i] <= nv_clamp[i].upper;
        margin_lower_clamp[i] <= nv_clamp[i].lower;
      end
    end else if (wr && bank == 4'h7) begin
      margin_upper_clamp[idx[1:0]] <= pwdata[7:0];
    end else if (wr && bank == 4'h8) begin
      margin_lower_clamp[idx[1:0]] <= pwdata[7:0];
    end
  end

  // comparisons on the values about to be published
  always_comb begin
    for (int i = 0; i < SMD_ADC_CH; i++) begin
      if (avg) begin
        next_result[i] = acc[i][SMD_ADC_W+3:SMD_AVG_SHIFT];
      end else begin
        next_result[i] = result[i];
      end
      if (!ch_sel[i]) begin
        next_warn[i] = 1'b0;
      end else if (lim_dir[i]) begin
        next_warn[i] = next_result[i] > thresh[i];
      end else begin
        next_warn[i] = next_result[i] < thresh[i];
      end
    end
  end

  // round-robin sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      ch <= '0;
      pass_cnt <= '0;
      dwell_cnt <= '0;
      adc_start <= 1'b0;
      adc_channel <= '0;
      once_done <= 1'b0;
      publish <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      once_done <= 1'b0;
      publish <= 1'b0;
      if (!active && state != st_idle) begin
        state <= st_idle; // aborted mid loop
      end else begin
        unique case (state)
          st_idle: begin
            ch <= '0;
            pass_cnt <= '0;
            if (active && ch_sel != '0) begin
              state <= st_pick;
            end
          end
          st_pick: begin
            if (ch_sel[ch]) begin
              adc_start <= 1'b1;
              adc_channel <= ch;
              dwell_cnt <= '0;
              state <= st_conv;
            end else begin
              state <= st_next;
            end
          end
          st_conv: begin
            dwell_cnt <= dwell_cnt + 1'b1;
            if (adc_done) begin
              state <= st_dwell;
            end
          end
          st_dwell: begin
            dwell_cnt <= dwell_cnt + 1'b1;
            if (dwell_cnt >= SMD_DWELL_W'(dwell_cycles - 1)) begin
              state <= st_next;
            end
          end
          st_next: begin
            ch <= ch + 1'b1;
            state <= (ch == 3'd7) ? st_pass : st_pick;
          end
          st_pass: begin
            pass_cnt <= pass_cnt + 1'b1;
            if (!avg || pass_cnt == 4'(SMD_AVG_PASSES - 1)) begin
              publish <= 1'b1;
              pass_cnt <= '0;
            end
            if (cont || (avg && pass_cnt != 4'(SMD_AVG_PASSES - 1))) begin
              state <= st_pick;
            end else begin
              once_done <= 1'b1;
              state <= st_hold;
            end
          end
          st_hold: begin
            state <= st_hold; // wait for the request to drop
          end
        endcase
      end
    end
  end

  // conversion results, summed when averaging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SMD_ADC_CH; i++) begin
        result[i] <= '0;
        acc[i] <= '0;
      end
    end else if (state == st_conv && adc_done) begin
      if (!avg) begin
        result[ch] <= adc_result;
      end else if (pass_cnt == 4'h0) begin
        acc[ch] <= {4'h0, adc_result};
      end else begin
        acc[ch] <= acc[ch] + {4'h0, adc_result};
      end
    end else if (publish && avg) begin
      for (int i = 0; i < SMD_ADC_CH; i++) begin
        if (ch_sel[i]) begin
          result[i] <= next_result[i];
        end
      end
    end
  end

  // warnings change only at the end of a pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn <= '0;
      sequencing_engine_warn <= '0;
    end else if (publish) begin
      warn <= next_warn;
      sequencing_engine_warn <= next_warn;
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
      int_mask <= '0;
    end else begin
      if (wr && paddr == SMD_INT_MASK) begin
        int_mask <= pwdata[SMD_INT_W-1:0];
      end
      int_stat <= (int_stat & ~((wr && paddr == SMD_INT_STAT) ? pwdata[SMD_INT_W-1:0] : '0))
        | {publish, publish ? (next_warn & ~warn) : 8'h00};
    end
  end

  // level interrupt, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // one clamp channel per margining dac
  for (genvar g = 0; g < SMD_DAC_CH; g++) begin : g_dac
    smd_dac_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .margin_code(margin_code[g]),
      .margin_upper_clamp(margin_upper_clamp[g]),
      .margin_lower_clamp(margin_lower_clamp[g]),
      .cfg(dcfg[g]),
      .dac_out(dac_out[g])
    );
  end
endmodule : smd_top

// ===== verif/smd_checker_properties.sv
`timescale 1ns/1ps
// port-level checker for the margining and limit block
module smd_checker
  import smd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  input wire logic nv_load,
  input wire smd_clamp_t [SMD_DAC_CH-1:0] nv_clamp,
  input wire smd_dac_out_t [SMD_DAC_CH-1:0] dac_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase still waiting for its answer
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // no new conversion during a short dwell
  sequence s_quiet;
    !adc_start [*8];
  endsequence
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_answer;
    s_access |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("apb access not answered");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_start_dwell;
    adc_start |=> s_quiet;
  endproperty
  a_start_dwell: assert property (p_start_dwell) else $error("conversions too close");
  property p_chan_hold;
    !adc_start |-> $stable(adc_channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("adc channel moved without start");
  property p_nv_hiz;
    nv_load && (nv_clamp[2].lower > nv_clamp[2].upper) |-> ##[1:3] dac_out[2].hiz;
  endproperty
  a_nv_hiz: assert property (p_nv_hiz) else $error("inverted clamps left buffer on");
  property p_nv_clamp;
    nv_load && (nv_clamp[0].lower <= nv_clamp[0].upper) |-> ##[1:3]
      (dac_out[0].code >= nv_clamp[0].lower && dac_out[0].code <= nv_clamp[0].upper);
  endproperty
  a_nv_clamp: assert property (p_nv_clamp) else $error("code outside loaded clamps");
  property p_track_first;
    $rose(dac_out[1].drive) |-> $past(dac_out[1].track, 8);
  endproperty
  a_track_first: assert property (p_track_first) else $error("drive without tracking");
endmodule : smd_checker

// ===== verif/smd_adc_model.sv
`timescale 1ns/1ps
// converter model: fixed latency, per-channel result
module smd_adc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  output logic adc_done,
  output logic [11:0] adc_result
);
  logic [2:0] wait_cnt; // conversion latency count
  logic [11:0] junk; // changing filler between results
  // results stay 12-bit unsigned
  function automatic logic [11:0] res_of(input logic [2:0] ch);
    return (ch == 3'h0) ? 12'h200 : (ch == 3'h1) ? 12'h900 : 12'h050;
  endfunction : res_of
  // done pulses four cycles after start; result only valid with done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 3'h0;
      adc_done <= 1'b0;
      junk <= 12'ha5a;
    end else begin
      junk <= ~junk;
      adc_done <= (wait_cnt == 3'h1);
      if (adc_start) wait_cnt <= 3'h3;
      else if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
    end
  end
  // filler changes each cycle so a stale read cannot pass
  assign adc_result = adc_done ? res_of(adc_channel) : junk;
endmodule : smd_adc_model

// ===== verif/smd_top_tb.sv
`timescale 1ns/1ps
module smd_top_tb
  import smd_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rr_on = 1'b0, nv_load = 1'b0, adc_start, adc_done, irq;
  logic [SMD_ADC_CH-1:0] warn;
  logic [2:0] adc_channel;
  logic [11:0] adc_result;
  smd_clamp_t [SMD_DAC_CH-1:0] nv_clamp = '0;
  smd_dac_out_t [SMD_DAC_CH-1:0] dac_out;
  int n_fail = 0, n_tests = 0;
  // short dwell keeps the run brief
  smd_top #(.dwell_cycles(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sequencing_engine_rr_on(rr_on), .sequencing_engine_warn(warn), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_result(adc_result), .nv_load(nv_load),
    .nv_clamp(nv_clamp), .dac_out(dac_out), .irq(irq));
  smd_adc_model adc_u (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_result(adc_result));
  always #2 pclk = ~pclk;
  // one comparison, counted
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // apb master: hold request until pready sampled high; a hung slave is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // bounded wait for a port condition
  task automatic wait_irq(input logic lvl);
    int k;
    for (k = 0; k < 3000 && irq !== lvl; k++) @(posedge pclk);
  endtask : wait_irq
  // reset values and refused addresses
  task automatic t_regs();
    apb(0, SMD_MCODE, 0); chk("code_rst", rd, 32'h7f);
    apb(0, SMD_UCLAMP, 0); chk("upper_rst", rd, 32'hff);
    apb(0, SMD_LCLAMP, 0); chk("lower_rst", rd, 32'h00);
    apb(0, SMD_THRESH, 0); chk("thr_rst", rd, 32'hfff);
    apb(0, 8'hfc, 0); chk("unmapped", er, 1);
    apb(1, 8'h61, 32'h12); chk("unaligned", er, 1);
    $display("test regs done");
  endtask : t_regs
  // clamp pair loaded from nonvolatile copy, also inverted; runs after t_drive so channel 2 drives
  task automatic t_nv();
    nv_clamp <= {4{16'h4030}};
    nv_load <= 1'b1; @(posedge pclk); nv_load <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("nv_code", dac_out[0].code, 8'h40);
    chk("nv_drive", dac_out[2].hiz, 0);
    apb(0, SMD_LCLAMP, 0); chk("nv_lower", rd, 32'h30);
    nv_clamp <= {4{16'h4050}};
    nv_load <= 1'b1; @(posedge pclk); nv_load <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("nv_hiz", dac_out[2].hiz, 1);
    nv_clamp <= {4{16'hff00}};
    nv_load <= 1'b1; @(posedge pclk); nv_load <= 1'b0;
    $display("test nv done");
  endtask : t_nv
  // written code against clamp pairs, full code span
  task automatic t_clamp();
    logic [7:0] tb [6][4] = '{'{8'h00, 8'h10, 8'hf0, 8'h10}, '{8'hff, 8'h10, 8'hf0, 8'hf0},
      '{8'h10, 8'h10, 8'hf0, 8'h10}, '{8'h80, 8'h10, 8'hf0, 8'h80},
      '{8'hff, 8'h00, 8'hff, 8'hff}, '{8'h00, 8'h00, 8'hff, 8'h00}};
    foreach (tb[i]) begin
      apb(1, SMD_LCLAMP + 8'h04, {24'h0, tb[i][1]});
      apb(1, SMD_UCLAMP + 8'h04, {24'h0, tb[i][2]});
      apb(1, SMD_MCODE + 8'h04, {24'h0, tb[i][0]});
      repeat (3) @(posedge pclk);
      chk("applied_code", dac_out[1].code, tb[i][3]);
    end
    $display("test clamp done");
  endtask : t_clamp
  // glitchless enable, ranges, inverted clamps three-state
  task automatic t_drive();
    int n;
    apb(1, SMD_MCODE + 8'h04, 32'h80);
    apb(1, SMD_DCFG + 8'h08, 32'h1);
    apb(1, SMD_DCFG + 8'h04, 32'h7);
    for (n = 0; n < 700 && dac_out[1].drive !== 1'b1; n++) begin
      @(posedge pclk);
      if (n == 10) chk("track", {dac_out[1].track, dac_out[1].drive}, 2'b10);
    end
    chk("drive_delay", (n >= 500 && n <= 504), 1);
    chk("driven_hiz", dac_out[1].hiz, 0);
    chk("loop_code", dac_out[1].code, 8'h80);
    for (int r = 0; r < 4; r++) begin
      apb(1, SMD_DCFG + 8'h04, 32'(r * 2 + 1));
      repeat (3) @(posedge pclk);
      chk("range", dac_out[1].range, r);
    end
    apb(1, SMD_LCLAMP + 8'h04, 32'h90);
    apb(1, SMD_UCLAMP + 8'h04, 32'h20);
    repeat (3) @(posedge pclk);
    chk("inv_hiz", dac_out[1].hiz, 1);
    $display("test drive done");
  endtask : t_drive
  // single software pass, warning, status and interrupt
  task automatic t_loop();
    apb(1, SMD_THRESH, 32'h100);
    apb(1, SMD_THRESH + 8'h04, 32'h800);
    apb(1, SMD_LIM_DIR, 32'h01);
    apb(1, SMD_CH_SEL, 32'h03);
    apb(1, SMD_INT_MASK, 32'h1ff);
    apb(1, SMD_CTRL, 32'h1);
    wait_irq(1);
    chk("irq_set", irq, 1);
    chk("seq_warn", warn, 8'h01);
    apb(0, SMD_LIM_STAT, 0); chk("lim_stat", rd, 32'h01);
    apb(0, SMD_INT_STAT, 0); chk("int_stat", rd, 32'h101);
    apb(0, SMD_RESULT + 8'h04, 0); chk("result1", rd, 32'h900);
    apb(0, SMD_CTRL, 0); chk("once_clear", rd, 32'h0);
    apb(1, SMD_INT_MASK, 32'h0); repeat (3) @(posedge pclk);
    chk("irq_masked", irq, 0);
    apb(1, SMD_INT_MASK, 32'h1ff); repeat (3) @(posedge pclk);
    chk("irq_unmask", irq, 1);
    apb(1, SMD_INT_STAT, 32'h1ff); repeat (3) @(posedge pclk);
    chk("irq_clear", irq, 0);
    $display("test loop done");
  endtask : t_loop
  // sequencer starts the loop; dwell between selected channels
  task automatic t_seq();
    int n;
    apb(1, SMD_THRESH + 8'h04, 32'ha00);
    rr_on <= 1'b1;
    for (n = 0; n < 100 && adc_start !== 1'b1; n++) @(posedge pclk);
    chk("seq_start", adc_start, 1);
    chk("first_ch", adc_channel, 3'h0);
    @(posedge pclk);
    for (n = 1; n < 100 && adc_start !== 1'b1; n++) @(posedge pclk);
    chk("dwell", (n >= 20), 1);
    chk("next_ch", adc_channel, 3'h1);
    wait_irq(1);
    chk("seq_irq", irq, 1);
    chk("seq_warn2", warn, 8'h03);
    rr_on <= 1'b0;
    $display("test seq done");
  endtask : t_seq
  // continuous averaged loop: results only after 16 passes, enable kept
  task automatic t_avg();
    apb(1, SMD_INT_STAT, 32'h1ff);
    apb(1, SMD_CH_SEL, 32'h04);
    apb(1, SMD_CTRL, 32'h7);
    repeat (100) @(posedge pclk);
    apb(0, SMD_RESULT + 8'h08, 0); chk("avg_early", rd, 32'h0);
    chk("avg_quiet", irq, 0);
    wait_irq(1);
    chk("avg_irq", irq, 1);
    chk("avg_warn", warn, 8'h04);
    apb(0, SMD_RESULT + 8'h08, 0); chk("avg_result", rd, 32'h050);
    apb(0, SMD_CTRL, 0); chk("cont_en", rd, 32'h7);
    apb(1, SMD_CTRL, 32'h0);
    $display("test avg done");
  endtask : t_avg
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clamp();
    t_drive();
    t_nv();
    t_loop();
    t_seq();
    t_avg();
    conclude();
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    conclude();
  end
endmodule : smd_top_tb
bind smd_top smd_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .adc_start(adc_start), .adc_channel(adc_channel),
  .nv_load(nv_load), .nv_clamp(nv_clamp), .dac_out(dac_out));
